// ==== prio_bank.sv ====
// APB register bank holding three interrupt priority registers
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "prio_map.svh"
module prio_bank
    import prio_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pending requests from sources, asynchronous to this block
    input wire logic [11:0] src_pending,
    // Field values for the selection logic
    output logic [2:0] uart_one_rx_priority,
    output logic [2:0] spi_one_event_priority,
    output logic [2:0] spi_one_error_priority,
    output logic [2:0] timer_three_priority,
    output logic [2:0] timer_four_priority,
    output logic [2:0] compare_four_priority,
    output logic [2:0] compare_three_priority,
    output logic [2:0] dma_two_done_priority,
    output logic [2:0] can_event_priority,
    output logic [2:0] can_rx_ready_priority,
    output logic [2:0] spi_two_event_priority,
    output logic [2:0] spi_two_error_priority,
    // Selected source
    output logic irq_valid,
    output logic [3:0] irq_id,
    output logic [2:0] irq_level
);
    prio_word_t priority_ctrl_serial_timer3; // First register
    prio_word_t priority_ctrl_timer4_compare_dma; // Second register
    prio_word_t priority_ctrl_can_spi2; // Third register
    logic [11:0] pend_meta; // First sync stage, read only by stage two
    logic [11:0] pend_sync; // Synchronised pending
    logic [35:0] levels; // All fields packed, source 0 lowest
    logic [15:0] next_word; // Merged write value
    logic wr_en; // Write strobe this cycle
    logic rd_en; // Read strobe this cycle
    apb_state_t state; // Tracks bus phase; read by no other logic

    // Map an address to a register index; 3 means unmapped
    function automatic logic [1:0] reg_index(input logic [11:0] a);
        case (a)
            `ADDR_SERIAL_TIMER3: reg_index = 2'd0;
            `ADDR_TIMER4_COMPARE_DMA: reg_index = 2'd1;
            `ADDR_CAN_SPI2: reg_index = 2'd2;
            default: reg_index = 2'd3;
        endcase
    endfunction

    // Merge write data by byte lane and keep only field bits
    function automatic prio_word_t merge(input prio_word_t old, input logic [31:0] d,
                                         input logic [3:0] s);
        prio_word_t m;
        m = old;
        if (s[0]) begin
            m[7:0] = d[7:0];
        end
        if (s[1]) begin
            m[15:8] = d[15:8];
        end
        merge = m & `IMPL_MASK; // see RL4, RL9
    endfunction

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    // Unmapped registers answer with an error rather than silently
    assign pslverr = psel && penable && reg_index(paddr) == 2'd3 &&
                     paddr != `ADDR_SELECT;

    // Write data merged for whichever register is addressed
    always_comb begin
        case (reg_index(paddr))
            2'd0: next_word = merge(priority_ctrl_serial_timer3, pwdata, pstrb);
            2'd1: next_word = merge(priority_ctrl_timer4_compare_dma, pwdata, pstrb);
            2'd2: next_word = merge(priority_ctrl_can_spi2, pwdata, pstrb);
            default: next_word = 16'h0000;
        endcase
    end

    // First register: uart rx, spi1 event, spi1 error, timer3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_ctrl_serial_timer3 <= `REG_RESET; // see RL3
        end else if (wr_en && reg_index(paddr) == 2'd0) begin
            priority_ctrl_serial_timer3 <= next_word; // see RL3, RL9
        end
    end

    // Second register: timer4, compare4, compare3, dma2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_ctrl_timer4_compare_dma <= `REG_RESET; // see RL3
        end else if (wr_en && reg_index(paddr) == 2'd1) begin
            priority_ctrl_timer4_compare_dma <= next_word; // see RL9
        end
    end

    // Third register: can event, can rx, spi2 event, spi2 error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_ctrl_can_spi2 <= `REG_RESET; // see RL3
        end else if (wr_en && reg_index(paddr) == 2'd2) begin
            priority_ctrl_can_spi2 <= next_word; // see RL9
        end
    end

    // Bus phase tracker; the read capture and all other logic ignore it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (psel) begin
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    state <= ST_ACCESS;
                end
                ST_ACCESS: begin
                    // Back-to-back transfers go straight to a new setup
                    state <= psel ? ST_SETUP : ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data captured in the setup cycle so it stands registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (reg_index(paddr))
                // Unimplemented bits held zero, so reads show zero
                2'd0: prdata <= {16'h0000, priority_ctrl_serial_timer3}; // see RL4
                2'd1: prdata <= {16'h0000, priority_ctrl_timer4_compare_dma};
                2'd2: prdata <= {16'h0000, priority_ctrl_can_spi2};
                default: begin
                    // Selection status; anything else reads zero
                    if (paddr == `ADDR_SELECT) begin
                        prdata <= {24'h0, irq_valid, irq_level, irq_id};
                    end else begin
                        prdata <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // Two-flop synchroniser for the asynchronous pending lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_meta <= 12'h000;
            pend_sync <= 12'h000;
        end else begin
            pend_meta <= src_pending;
            pend_sync <= pend_meta;
        end
    end

    // Field placement per register
    assign uart_one_rx_priority = priority_ctrl_serial_timer3[14:12]; // see RL5
    assign spi_one_event_priority = priority_ctrl_serial_timer3[10:8]; // see RL5
    assign spi_one_error_priority = priority_ctrl_serial_timer3[6:4]; // see RL5
    assign timer_three_priority = priority_ctrl_serial_timer3[2:0]; // see RL5
    assign timer_four_priority = priority_ctrl_timer4_compare_dma[14:12]; // see RL6
    assign compare_four_priority = priority_ctrl_timer4_compare_dma[10:8]; // see RL6
    assign compare_three_priority = priority_ctrl_timer4_compare_dma[6:4]; // see RL6
    assign dma_two_done_priority = priority_ctrl_timer4_compare_dma[2:0]; // see RL6
    assign can_event_priority = priority_ctrl_can_spi2[14:12]; // see RL7
    assign can_rx_ready_priority = priority_ctrl_can_spi2[10:8]; // see RL7
    assign spi_two_event_priority = priority_ctrl_can_spi2[6:4]; // see RL7
    assign spi_two_error_priority = priority_ctrl_can_spi2[2:0]; // see RL7

    // Source order for the selector: index 0 is uart rx, 11 is spi2 error
    assign levels = {spi_two_error_priority, spi_two_event_priority,
                     can_rx_ready_priority, can_event_priority,
                     dma_two_done_priority, compare_three_priority,
                     compare_four_priority, timer_four_priority,
                     timer_three_priority, spi_one_error_priority,
                     spi_one_event_priority, uart_one_rx_priority};

    // Priority selection; disabled fields never win
    prio_select u_select (
        .pclk(pclk),
        .presetn(presetn),
        .levels(levels),
        .pending(pend_sync),
        .win_valid(irq_valid),
        .win_id(irq_id),
        .win_level(irq_level)
    );
endmodule

// ==== prio_map.svh ====
// Register map, field layout and reset constants for the priority bank
// Function
// (RL1) Field value is binary level, 111 highest
// (RL2) Field 000 disables its source entirely
// (RL3) Fields read/write, reset to binary 100
// (RL4) Bits 15,11,7,3 read zero, ignore writes
// (RL5) First register: uart rx, spi1 event/error, timer3
// (RL6) Second register: timer4, compare4, compare3, dma2
// (RL7) Third register: can event/rx, spi2 event/error
// (RL8) Software programs equal nonzero levels for flat
// (RL9) Writes touch only field bits, no side effect
`ifndef PRIO_MAP_SVH
`define PRIO_MAP_SVH
`define ADDR_SERIAL_TIMER3 12'h000
`define ADDR_TIMER4_COMPARE_DMA 12'h004
`define ADDR_CAN_SPI2 12'h008
`define ADDR_SELECT 12'h00c
`define FIELD_RESET 3'h4
`define FIELD_OFF 3'h0
`define IMPL_MASK 16'h7777
`define REG_RESET 16'h4444
`define NUM_REGS 3
`define NUM_SRC 12
`endif

// ==== prio_pkg.sv ====
// Types shared by the priority bank files
package prio_pkg;
    typedef logic [2:0] level_t;
    typedef logic [15:0] prio_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_ACCESS = 3'b100
    } apb_state_t;
endpackage

// ==== prio_select.sv ====
// Picks the highest enabled pending source from the priority fields
`timescale 1ns/1ns
`include "prio_map.svh"
module prio_select
    import prio_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Field levels and pending requests
    input wire logic [35:0] levels,
    input wire logic [11:0] pending,
    // Winner
    output logic win_valid,
    output logic [3:0] win_id,
    output level_t win_level
);
    level_t best_level; // Running best level
    logic [3:0] best_id; // Running best index
    logic best_found; // Any enabled pending source

    // Scan sources; lower index wins ties
    always_comb begin
        best_level = `FIELD_OFF;
        best_id = 4'h0;
        best_found = 1'b0;
        for (int i = 0; i < `NUM_SRC; i++) begin
            // Level 000 never qualifies, higher binary beats lower
            if (pending[i] && levels[i*3 +: 3] != `FIELD_OFF &&
                levels[i*3 +: 3] > best_level) begin // see RL1, RL2
                best_level = levels[i*3 +: 3];
                best_id = 4'(i);
                best_found = 1'b1;
            end
        end
    end

    // Register the winner so data outputs come from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_valid <= 1'b0;
            win_id <= 4'h0;
            win_level <= 3'h0;
        end else begin
            win_valid <= best_found;
            win_id <= best_id;
            win_level <= best_level;
        end
    end
endmodule

// ==== prio_bank_properties.sv ====
// Checker for the priority bank bus, field and selection behaviour
`timescale 1ns/1ns
module prio_bank_chk (
    // Bus side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Fields and selection
    input wire logic [2:0] uart_one_rx_priority,
    input wire logic [2:0] timer_three_priority,
    input wire logic [11:0] src_pending,
    input wire logic irq_valid,
    input wire logic [3:0] irq_id,
    input wire logic [2:0] irq_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase of any transfer
    wire acc = psel && penable;
    // Write data of the previous cycle, so field checks avoid slicing $past
    logic [31:0] last_wdata;
    always_ff @(posedge pclk) begin
        last_wdata <= pwdata;
    end
    property p_rsv_zero;
        acc && !pwrite && paddr < 12'h00c |-> (prdata & 32'hffff8888) == 32'h0; endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");
    property p_rd_fields;
        acc && !pwrite && paddr == 12'h000 |-> prdata[14:12] == uart_one_rx_priority
            && prdata[2:0] == timer_three_priority; endproperty
    a_rd_fields: assert property (p_rd_fields) else $error("readback differs");
    property p_wr_hi;
        acc && pwrite && paddr == 12'h000 && pstrb[1]
            |=> uart_one_rx_priority == last_wdata[14:12]; endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("upper field not written");
    property p_wr_lo;
        acc && pwrite && paddr == 12'h000 && pstrb[0]
            |=> timer_three_priority == last_wdata[2:0]; endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("lower field not written");
    property p_hold;
        !(acc && pwrite && paddr == 12'h000)
            |=> $stable(uart_one_rx_priority) && $stable(timer_three_priority); endproperty
    a_hold: assert property (p_hold) else $error("field moved without write");
    property p_err;
        acc && paddr >= 12'h010 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped access");
    property p_off;
        irq_valid |-> irq_level != 3'h0; endproperty
    a_off: assert property (p_off) else $error("disabled level selected");
    property p_lvl0;
        irq_valid && irq_id == 4'h0 |-> irq_level == $past(uart_one_rx_priority); endproperty
    a_lvl0: assert property (p_lvl0) else $error("winner level wrong");
    property p_quiet;
        (src_pending == 12'h000) [*4] |=> !irq_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("selection without request");
endmodule
bind prio_bank prio_bank_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pslverr, .uart_one_rx_priority, .timer_three_priority,
    .src_pending, .irq_valid, .irq_id, .irq_level);

// ==== prio_bank_tb.sv ====
// Self-checking bench for the priority register bank
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module prio_bank_tb;
    // Bus and source drive
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0, src_pending = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0, irq_id;
    logic pready, pslverr, irq_valid, err;
    logic [2:0] irq_level;
    logic [2:0] f [12]; // Field outputs in source index order
    int num_errors = 0, samples_checked = 0;
    prio_bank u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .src_pending, .uart_one_rx_priority(f[0]),
        .spi_one_event_priority(f[1]), .spi_one_error_priority(f[2]),
        .timer_three_priority(f[3]), .timer_four_priority(f[4]), .compare_four_priority(f[5]),
        .compare_three_priority(f[6]), .dma_two_done_priority(f[7]),
        .can_event_priority(f[8]), .can_rx_ready_priority(f[9]),
        .spi_two_event_priority(f[10]), .spi_two_error_priority(f[11]),
        .irq_valid, .irq_id, .irq_level);
    // 25 MHz clock
    initial begin
        forever #20 pclk = ~pclk;
    end
    // Field outputs of one register packed as its bus word
    function automatic logic [15:0] word(int r);
        return {1'b0, f[4*r], 1'b0, f[4*r+1], 1'b0, f[4*r+2], 1'b0, f[4*r+3]};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic t_reset();
        for (int r = 0; r < 3; r++) begin
            apb(1'b0, 12'(4 * r), 32'h0, 4'h0);
            `CHK(rd, 32'h4444)
            `CHK(word(r), 16'h4444)
        end
        $display("reset values done");
    endtask
    task automatic t_fields();
        logic [31:0] wv [3] = '{32'hffff1234, 32'h00005670, 32'h0000f0f1};
        logic [15:0] ev [3] = '{16'h1234, 16'h5670, 16'h7071};
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, 12'(4 * r), wv[r], 4'hf);
            apb(1'b0, 12'(4 * r), 32'h0, 4'h0);
            `CHK(rd, {16'h0, ev[r]})
            `CHK(word(r), ev[r])
        end
        $display("field layout done");
    endtask
    // Field outputs settle after the write edge, so look half a cycle later
    task automatic t_strobe();
        apb(1'b1, 12'h000, 32'h0, 4'h1);
        @(negedge pclk);
        `CHK(word(0), 16'h1200)
        apb(1'b1, 12'h000, 32'h6000, 4'hc);
        @(negedge pclk);
        `CHK(word(0), 16'h1200)
        apb(1'b1, 12'h000, 32'h6000, 4'h2);
        @(negedge pclk);
        `CHK(word(0), 16'h6000)
        $display("byte strobes done");
    endtask
    task automatic t_refuse();
        apb(1'b1, 12'h010, 32'hffffffff, 4'hf);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h00c, 32'hffffffff, 4'hf);
        @(negedge pclk);
        `CHK(err, 1'b0)
        `CHK(word(0), 16'h6000)
        $display("refused accesses done");
    endtask
    // Levels: uart 6, timer4 7, can rx 3, spi2 event 3, all others off
    task automatic t_select();
        logic [11:0] pend [4] = '{12'hfff, 12'h00e, 12'h601, 12'h600};
        logic [7:0] ex [4] = '{8'hf4, 8'h00, 8'he0, 8'hb9};
        apb(1'b1, 12'h004, 32'h7000, 4'h3);
        apb(1'b1, 12'h008, 32'h0330, 4'h3);
        for (int i = 0; i < 4; i++) begin
            src_pending <= pend[i];
            repeat (5) @(posedge pclk);
            `CHK({irq_valid, irq_level, irq_id}, ex[i])
            apb(1'b0, 12'h00c, 32'h0, 4'h0);
            `CHK(rd, {24'h0, ex[i]})
        end
        src_pending <= 12'h0;
        $display("selection done");
    endtask
    // Flat scheme: every field level 5, ties fall to the lowest index
    task automatic t_flat();
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, 12'(4 * r), 32'h5555, 4'h3);
        end
        src_pending <= 12'h0c0;
        repeat (5) @(posedge pclk);
        `CHK(word(1), 16'h5555)
        `CHK({irq_valid, irq_level, irq_id}, 8'hd6)
        src_pending <= 12'h0;
        repeat (5) @(posedge pclk);
        `CHK(irq_valid, 1'b0)
        $display("flat levels done");
    endtask
    // Main sequence, with a second reset in mid-run
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_strobe();
        t_refuse();
        t_select();
        t_flat();
        repeat (5) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        end_sim();
    end
endmodule
